// ### rtl/temu_consts.svh
// Constants of the emulator control block: bit positions, map limits.
// Assumes inclusion by bare name from files that need them.
`ifndef TEMU_CONSTS_SVH
`define TEMU_CONSTS_SVH
// Displacement of the first control bit on the bit bus
`define TEMU_CTRL_BASE  5'h10
// Control word positions (displacement minus 16)
`define TEMU_C_HOLD     4'h0
`define TEMU_C_TRAP     4'h1
`define TEMU_C_MEM      4'h2
`define TEMU_C_TC       4'h3
`define TEMU_C_CR       4'h4
`define TEMU_C_TM       4'h5
`define TEMU_C_UM       4'h6
`define TEMU_C_AH       4'h7
`define TEMU_C_IMASK    4'h8
`define TEMU_C_CS       4'h9
`define TEMU_C_TB       4'hc
`define TEMU_C_XB       4'hd
// Hold requested, interrupts masked, everything else off
`define TEMU_CTRL_RST   16'h0100
// Trace and compare function codes
`define TEMU_FN_OFF     2'h0
`define TEMU_FN_ADDR    2'h1
`define TEMU_FN_ALL     2'h2
`define TEMU_FN_PC      2'h3
// Memory map
`define TEMU_USER_TOP   16'h1fff
`define TEMU_TRACE_BASE 16'hfe00
`define TEMU_RESET_VEC  16'h0000
`define TEMU_LOAD_VEC   16'hfffc
`define TEMU_TRACE_PAGE 7'h7f
`endif

// ### rtl/temu_pkg.sv
// Types of the emulator control block.
// Assumes nothing of its surroundings.
package temu_pkg;
	typedef logic [15:0] temu_word_type;
	typedef enum logic [1:0] {
		CMD_IDLE,
		CMD_INT_WAIT,
		CMD_INT_DATA,
		CMD_TGT_WAIT
	} temu_cmd_type;
endpackage : temu_pkg

// ### rtl/temu_core_if.sv
// Internal carrier between the control core, its memories and its matcher.
// Assumes one clock shared by all users.
`timescale 1ns/1ns
`default_nettype none
interface temu_core_if;
	// Memory ports
	logic                   a_en, a_we, b_en, b_we;
	temu_pkg::temu_word_type a_addr, a_wdata, a_rdata;
	temu_pkg::temu_word_type b_addr, b_wdata, b_rdata;
	// Matcher inputs and results
	logic                   cyc_end, cpu_we, cpu_iaq, trc_clk_en, running, cs;
	temu_pkg::temu_word_type cpu_addr, cmp_val;
	logic [1:0]             tf, cf;
	logic                   trace_hit, cmp_hit;
	modport mem (input a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
		output a_rdata, b_rdata);
	modport match (input cyc_end, cpu_we, cpu_iaq, trc_clk_en, running, cs,
		cpu_addr, cmp_val, tf, cf, output trace_hit, cmp_hit);
endinterface : temu_core_if
`default_nettype wire

// ### rtl/temu_memory.sv
// User memory (4K words) and trace/control memory (256 words), two ports.
// Assumes byte addresses; bit 0 ignored; read data one cycle after enable.
`timescale 1ns/1ns
`default_nettype none
`include "temu_consts.svh"
module temu_memory (
	// Clock
	input wire logic clk,
	// Ports
	temu_core_if.mem bus
);
	logic [15:0] user_mem  [0:4095];
	logic [15:0] trace_mem [0:255];
	logic        a_user, b_user;
	logic [15:0] a_q, b_q;

	// Low 8K bytes hit the user array, the rest the trace array
	assign a_user = (bus.a_addr <= `TEMU_USER_TOP);
	assign b_user = (bus.b_addr <= `TEMU_USER_TOP);

	// User array writes, port B last
	always_ff @(posedge clk) begin
		if (bus.a_en && bus.a_we && a_user) begin
			user_mem[bus.a_addr[12:1]] <= bus.a_wdata;
		end
		if (bus.b_en && bus.b_we && b_user) begin
			user_mem[bus.b_addr[12:1]] <= bus.b_wdata;
		end
	end

	// Trace array writes, port B last
	always_ff @(posedge clk) begin
		if (bus.a_en && bus.a_we && !a_user) begin
			trace_mem[bus.a_addr[8:1]] <= bus.a_wdata;
		end
		if (bus.b_en && bus.b_we && !b_user) begin
			trace_mem[bus.b_addr[8:1]] <= bus.b_wdata;
		end
	end

	// Registered reads
	always_ff @(posedge clk) begin
		a_q <= a_user ? user_mem[bus.a_addr[12:1]] : trace_mem[bus.a_addr[8:1]];
		b_q <= b_user ? user_mem[bus.b_addr[12:1]] : trace_mem[bus.b_addr[8:1]];
	end

	assign bus.a_rdata = a_q;
	assign bus.b_rdata = b_q;
endmodule : temu_memory
`default_nettype wire

// ### rtl/temu_match.sv
// Trace qualifier and breakpoint comparator, purely combinational.
// Assumes the cycle-end strobe marks one finished target memory cycle.
`timescale 1ns/1ns
`default_nettype none
`include "temu_consts.svh"
module temu_match (
	// Inputs and results
	temu_core_if.match bus
);
	// Which cycles are traced and which compare
	always_comb begin
		bus.trace_hit = 1'b0;
		bus.cmp_hit   = 1'b0;
		if (bus.cyc_end && bus.running && (bus.cs || bus.trc_clk_en)) begin // RULE_12
			case (bus.tf) // RULE_25
				`TEMU_FN_ALL: bus.trace_hit = 1'b1;
				`TEMU_FN_PC:  bus.trace_hit = bus.cpu_iaq;
				default:      bus.trace_hit = 1'b0;
			endcase
		end
		if (bus.cyc_end && (bus.cpu_addr == bus.cmp_val)) begin
			case (bus.cf) // RULE_21 RULE_26
				`TEMU_FN_ADDR: bus.cmp_hit = bus.cpu_we;
				`TEMU_FN_ALL:  bus.cmp_hit = 1'b1;
				`TEMU_FN_PC:   bus.cmp_hit = bus.cpu_iaq;
				default:       bus.cmp_hit = 1'b0;
			endcase
		end
	end
endmodule : temu_match
`default_nettype wire

// ### rtl/temu_ctrl.sv
// Emulator control block: host bit bus, hold, traps, mapping, commands, trace.
// Assumes a host bit bus with one-cycle write strobes, all synchronous.
//
// Summary of operation
// RULE_01: Hold bit: 0 requests hold, 1 releases
// RULE_02: Host uses functions only after hold acknowledge
// RULE_03: Trap bit: 0 load trap, 1 reset trap
// RULE_04: Reset vector at 0000, load vector FFFC
// RULE_05: Trace map bit places FE00-FFFF in emulator
// RULE_06: User map bit places 0000-1FFF in emulator
// RULE_07: Memory bit: 1 load address and read
// RULE_08: Trace counter bit copies to or from data
// RULE_09: Compare bit copies to or from data
// RULE_10: Auto hold bit requests hold on breakpoint
// RULE_11: Mask bit 1 disables host interrupt
// RULE_12: Clock select: every cycle or external enables
// RULE_13: Host moves data only while target held
// RULE_14: Four events start a halt sequence
// RULE_15: Halt raises host interrupt when unmasked
// RULE_16: Halt with auto hold asserts hold request
// RULE_17: Store traced address then decrement counter
// RULE_18: Buffer full when counter steps one to zero
// RULE_19: Continuous mode halts on buffer full
// RULE_20: Otherwise tracing wraps over oldest entries
// RULE_21: Compare register match starts halt sequence
// RULE_22: Emulator memories unreachable by host DMA
// RULE_23: Status 17 reads 0 in hold
// RULE_24: Status 18 reads 1 while command pending
// RULE_25: Trace function field selects source
// RULE_26: Compare function field selects match
`timescale 1ns/1ns
`default_nettype none
`include "temu_consts.svh"
module temu_ctrl (
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	// Host bit bus
	input  wire logic [4:0]  BIT_ADDR,
	input  wire logic        BIT_WR,
	input  wire logic        BIT_WR_DATA,
	output logic             BIT_RD_DATA,
	output logic             HOST_INT,
	// Target control
	output logic             HOLD_REQ,
	input  wire logic        HOLD_ACK,
	input  wire logic        TGT_IDLE,
	input  wire logic        TGT_WIDE_CPU,
	input  wire logic        CLK_ERROR,
	output logic             TRAP_LOAD,
	output logic             TRAP_RESET,
	output logic [15:0]      TRAP_VEC,
	// Target processor bus
	input  wire logic        CPU_MEM_EN,
	input  wire logic        CPU_WE,
	input  wire logic        CPU_IAQ,
	input  wire logic        CPU_CYCLE_END,
	input  wire logic [15:0] CPU_ADDR,
	input  wire logic [15:0] CPU_WDATA,
	output logic             EMU_SEL,
	output logic [15:0]      CPU_RDATA,
	// Trace and breakpoint sources, edge connector output
	input  wire logic        TRACE_CLK_EN,
	input  wire logic        EXT_BREAK,
	input  wire logic        TRACE_MOD_HALT,
	output logic [15:0]      EDGE_OUT,
	// Target memory port
	output logic             TGT_REQ,
	output logic             TGT_WE,
	output logic [15:0]      TGT_ADDR,
	output logic [15:0]      TGT_WDATA,
	input  wire logic        TGT_ACK,
	input  wire logic [15:0] TGT_RDATA
);
	// ==========================================================
	// Declarations
	temu_core_if             core ();
	temu_pkg::temu_cmd_type  state_ff;
	temu_pkg::temu_word_type ctrl_ff, data_ff, madr_ff, cmp_reg_ff, tcnt_ff;
	logic                    wrote_ff, hb_en_ff, hb_we_ff;
	logic [15:0]             hb_addr_ff;
	logic                    buf_full_ff, trig_ff, int_pend_ff;
	logic                    ctrl_wr, data_wr, tc_load, full_evt, halt_evt;
	logic                    trace_wr;
	logic [31:0]             status;

	// Emulator owns an address when its map bit is set
	function automatic logic temu_is_internal(input logic [15:0] addr,
		input logic um, input logic tm);
		temu_is_internal = (um && (addr <= `TEMU_USER_TOP)) ||
			(tm && (addr >= `TEMU_TRACE_BASE)); // RULE_05 RULE_06
	endfunction : temu_is_internal

	// ==========================================================
	// Host bit decode
	assign ctrl_wr  = BIT_WR && BIT_ADDR[4];
	assign data_wr  = BIT_WR && !BIT_ADDR[4];
	assign tc_load  = ctrl_wr && (BIT_ADDR[3:0] == `TEMU_C_TC) && !BIT_WR_DATA
		&& (state_ff == temu_pkg::CMD_IDLE);

	// ==========================================================
	// Submodules
	assign core.cyc_end    = CPU_CYCLE_END;
	assign core.cpu_we     = CPU_WE;
	assign core.cpu_iaq    = CPU_IAQ;
	assign core.trc_clk_en = TRACE_CLK_EN;
	assign core.running    = !HOLD_ACK;
	assign core.cs         = ctrl_ff[`TEMU_C_CS];
	assign core.cpu_addr   = CPU_ADDR;
	assign core.cmp_val    = cmp_reg_ff;
	assign core.tf         = ctrl_ff[11:10];
	assign core.cf         = ctrl_ff[15:14];

	// Port A serves the target processor; only it, the host and trace stores reach memory
	assign core.a_en    = CPU_MEM_EN && temu_is_internal(CPU_ADDR,
		ctrl_ff[`TEMU_C_UM], ctrl_ff[`TEMU_C_TM]); // RULE_22
	assign core.a_we    = CPU_WE;
	assign core.a_addr  = CPU_ADDR;
	assign core.a_wdata = CPU_WDATA;

	// Port B: host commands first, trace stores otherwise
	assign trace_wr     = core.trace_hit && !hb_en_ff;
	assign core.b_en    = hb_en_ff || trace_wr;
	assign core.b_we    = hb_en_ff ? hb_we_ff : 1'b1;
	assign core.b_addr  = hb_en_ff ? hb_addr_ff : {`TEMU_TRACE_PAGE, tcnt_ff[7:0], 1'b0};
	assign core.b_wdata = hb_en_ff ? data_ff : CPU_ADDR; // RULE_17

	temu_memory u_mem (
		.clk (CORE_CLK),
		.bus (core)
	);

	temu_match u_match (
		.bus (core)
	);

	// ==========================================================
	// Halt sequence sources
	assign full_evt = trace_wr && (tcnt_ff == 16'h0001); // RULE_18
	assign halt_evt = (full_evt && ctrl_ff[`TEMU_C_TB]) || // RULE_19 RULE_14
		(ctrl_ff[`TEMU_C_XB] ? EXT_BREAK : core.cmp_hit) || // RULE_21
		TRACE_MOD_HALT;

	// ==========================================================
	// Control word; a halt with auto hold beats a host release
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			ctrl_ff <= `TEMU_CTRL_RST;
		end else begin
			if (ctrl_wr) begin
				ctrl_ff[BIT_ADDR[3:0]] <= BIT_WR_DATA; // RULE_01
			end
			if (halt_evt && ctrl_ff[`TEMU_C_AH]) begin
				ctrl_ff[`TEMU_C_HOLD] <= 1'b0; // RULE_10 RULE_16
			end
		end
	end

	// Hold request and host interrupt pins
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			HOLD_REQ <= 1'b1;
			HOST_INT <= 1'b0;
		end else begin
			HOLD_REQ <= !ctrl_ff[`TEMU_C_HOLD]; // RULE_01
			HOST_INT <= int_pend_ff && !ctrl_ff[`TEMU_C_IMASK]; // RULE_11 RULE_15
		end
	end

	// Interrupt pending: set by a halt, cleared by a mask bit write
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			int_pend_ff <= 1'b0;
		end else if (halt_evt) begin
			int_pend_ff <= 1'b1; // RULE_15
		end else if (ctrl_wr && (BIT_ADDR[3:0] == `TEMU_C_IMASK)) begin
			int_pend_ff <= 1'b0;
		end
	end

	// Trap pulses and the vector they point at
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			TRAP_LOAD  <= 1'b0;
			TRAP_RESET <= 1'b0;
			TRAP_VEC   <= `TEMU_RESET_VEC;
		end else begin
			TRAP_LOAD  <= 1'b0;
			TRAP_RESET <= 1'b0;
			if (ctrl_wr && (BIT_ADDR[3:0] == `TEMU_C_TRAP)) begin
				TRAP_LOAD  <= !BIT_WR_DATA; // RULE_03
				TRAP_RESET <= BIT_WR_DATA;
				TRAP_VEC   <= BIT_WR_DATA ? `TEMU_RESET_VEC : `TEMU_LOAD_VEC; // RULE_04
			end
		end
	end

	// ==========================================================
	// Host commands: data, address, compare registers and memory access
	// Commands are not gated on hold; the host issues them only in hold
	always_ff @(posedge CORE_CLK) begin // RULE_02 RULE_13
		if (RST) begin
			state_ff   <= temu_pkg::CMD_IDLE;
			data_ff    <= 16'h0000;
			madr_ff    <= 16'h0000;
			cmp_reg_ff <= 16'h0000;
			wrote_ff   <= 1'b0;
			hb_en_ff   <= 1'b0;
			hb_we_ff   <= 1'b0;
			hb_addr_ff <= 16'h0000;
			TGT_REQ    <= 1'b0;
			TGT_WE     <= 1'b0;
			TGT_ADDR   <= 16'h0000;
			TGT_WDATA  <= 16'h0000;
		end else begin
			hb_en_ff <= 1'b0;
			if (data_wr) begin
				data_ff[BIT_ADDR[3:0]] <= BIT_WR_DATA;
			end
			case (state_ff)
				temu_pkg::CMD_IDLE: begin
					if (ctrl_wr && (BIT_ADDR[3:0] == `TEMU_C_MEM)) begin // RULE_07
						wrote_ff <= !BIT_WR_DATA;
						if (BIT_WR_DATA) begin
							madr_ff <= data_ff;
						end
						if (temu_is_internal(BIT_WR_DATA ? data_ff : madr_ff,
							ctrl_ff[`TEMU_C_UM], ctrl_ff[`TEMU_C_TM])) begin
							hb_en_ff   <= 1'b1;
							hb_we_ff   <= !BIT_WR_DATA;
							hb_addr_ff <= BIT_WR_DATA ? data_ff : madr_ff;
							state_ff   <= temu_pkg::CMD_INT_WAIT;
						end else begin
							TGT_REQ   <= 1'b1;
							TGT_WE    <= !BIT_WR_DATA;
							TGT_ADDR  <= BIT_WR_DATA ? data_ff : madr_ff;
							TGT_WDATA <= data_ff;
							state_ff  <= temu_pkg::CMD_TGT_WAIT;
						end
					end else if (ctrl_wr && (BIT_ADDR[3:0] == `TEMU_C_TC) && BIT_WR_DATA) begin
						data_ff <= tcnt_ff; // RULE_08
					end else if (ctrl_wr && (BIT_ADDR[3:0] == `TEMU_C_CR)) begin
						if (BIT_WR_DATA) begin
							data_ff <= cmp_reg_ff; // RULE_09
						end else begin
							cmp_reg_ff <= data_ff; // RULE_09
						end
					end
				end
				temu_pkg::CMD_INT_WAIT: begin
					state_ff <= temu_pkg::CMD_INT_DATA;
				end
				temu_pkg::CMD_INT_DATA: begin
					if (wrote_ff) begin
						wrote_ff <= 1'b0; // Read back after write
						hb_en_ff <= 1'b1;
						hb_we_ff <= 1'b0;
						state_ff <= temu_pkg::CMD_INT_WAIT;
					end else begin
						data_ff  <= core.b_rdata; // RULE_07
						state_ff <= temu_pkg::CMD_IDLE;
					end
				end
				temu_pkg::CMD_TGT_WAIT: begin
					if (TGT_ACK && wrote_ff) begin
						wrote_ff <= 1'b0; // Read back after write
						TGT_WE   <= 1'b0;
					end else if (TGT_ACK) begin
						TGT_REQ  <= 1'b0;
						data_ff  <= TGT_RDATA; // RULE_07
						state_ff <= temu_pkg::CMD_IDLE;
					end
				end
				default: begin
					state_ff <= temu_pkg::CMD_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Trace counter; the 8-bit index wraps over the oldest entries
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			tcnt_ff <= 16'h0000;
		end else if (tc_load) begin
			tcnt_ff <= data_ff; // RULE_08
		end else if (trace_wr) begin
			tcnt_ff <= tcnt_ff - 16'h0001; // RULE_17 RULE_20
		end
	end

	// Buffer full and trace trigger flags; a new event beats the clear
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			buf_full_ff <= 1'b0;
			trig_ff     <= 1'b0;
		end else begin
			if (full_evt) begin
				buf_full_ff <= 1'b1; // RULE_18
			end else if (tc_load) begin
				buf_full_ff <= 1'b0;
			end
			if (full_evt && ctrl_ff[`TEMU_C_TB]) begin
				trig_ff <= 1'b1; // RULE_19
			end else if (tc_load) begin
				trig_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Target bus answers and edge connector output
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			EMU_SEL   <= 1'b0;
			CPU_RDATA <= 16'h0000;
			EDGE_OUT  <= 16'h0000;
		end else begin
			EMU_SEL   <= core.a_en; // RULE_05 RULE_06
			CPU_RDATA <= core.a_rdata;
			EDGE_OUT  <= (ctrl_ff[11:10] == `TEMU_FN_OFF) ? CPU_WDATA : CPU_ADDR; // RULE_25
		end
	end

	// ==========================================================
	// Status word seen on the host read bit
	assign status = {ctrl_ff[15:14], trig_ff, buf_full_ff, ctrl_ff[11:10],
		TGT_WIDE_CPU, int_pend_ff, TGT_IDLE, ctrl_ff[`TEMU_C_UM],
		ctrl_ff[`TEMU_C_TM], CLK_ERROR, 1'b0,
		(state_ff != temu_pkg::CMD_IDLE), // RULE_24
		!HOLD_ACK, // RULE_23
		ctrl_ff[`TEMU_C_HOLD], data_ff};

	// Registered read of the addressed bit
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			BIT_RD_DATA <= 1'b0;
		end else begin
			BIT_RD_DATA <= status[BIT_ADDR];
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	sequence s_bit_wr(logic [3:0] pos, logic val);
		ctrl_wr && (BIT_ADDR[3:0] == pos) && (BIT_WR_DATA == val);
	endsequence
	sequence s_idle;
		state_ff == temu_pkg::CMD_IDLE;
	endsequence

	property p_hold_release;
		s_bit_wr(`TEMU_C_HOLD, 1'b1) ##0 !halt_evt |-> ##2 !HOLD_REQ;
	endproperty
	a_hold_release: assert property (p_hold_release) else $error("hold not released"); // RULE_01
	property p_hold_req;
		s_bit_wr(`TEMU_C_HOLD, 1'b0) |-> ##2 HOLD_REQ;
	endproperty
	a_hold_req: assert property (p_hold_req) else $error("hold not requested"); // RULE_01
	property p_trap;
		ctrl_wr && (BIT_ADDR[3:0] == `TEMU_C_TRAP) |=>
			(TRAP_RESET == $past(BIT_WR_DATA)) && (TRAP_LOAD == !$past(BIT_WR_DATA));
	endproperty
	a_trap: assert property (p_trap) else $error("wrong trap"); // RULE_03
	property p_trap_vec;
		TRAP_LOAD |-> TRAP_VEC == `TEMU_LOAD_VEC;
	endproperty
	a_trap_vec: assert property (p_trap_vec) else $error("wrong load vector"); // RULE_04
	property p_map_trace;
		CPU_MEM_EN && (CPU_ADDR >= `TEMU_TRACE_BASE) && ctrl_ff[`TEMU_C_TM] |=> EMU_SEL;
	endproperty
	a_map_trace: assert property (p_map_trace) else $error("trace map missed"); // RULE_05
	property p_map_user_off;
		CPU_MEM_EN && (CPU_ADDR <= `TEMU_USER_TOP) && !ctrl_ff[`TEMU_C_UM] |=> !EMU_SEL;
	endproperty
	a_map_user_off: assert property (p_map_user_off) else $error("user map leak"); // RULE_06
	property p_int_read;
		s_bit_wr(`TEMU_C_MEM, 1'b1) ##0 s_idle ##0
			temu_is_internal(data_ff, ctrl_ff[`TEMU_C_UM], ctrl_ff[`TEMU_C_TM])
			|=> (state_ff != temu_pkg::CMD_IDLE)[*2] ##1 s_idle;
	endproperty
	a_int_read: assert property (p_int_read) else $error("read timing"); // RULE_07 RULE_24
	property p_tc_read;
		s_bit_wr(`TEMU_C_TC, 1'b1) ##0 s_idle ##0 !data_wr |=> data_ff == $past(tcnt_ff);
	endproperty
	a_tc_read: assert property (p_tc_read) else $error("counter copy lost"); // RULE_08
	property p_cr_load;
		s_bit_wr(`TEMU_C_CR, 1'b0) ##0 s_idle |=> cmp_reg_ff == $past(data_ff);
	endproperty
	a_cr_load: assert property (p_cr_load) else $error("compare load lost"); // RULE_09
	property p_autohold;
		halt_evt && ctrl_ff[`TEMU_C_AH] |-> ##2 HOLD_REQ;
	endproperty
	a_autohold: assert property (p_autohold) else $error("no auto hold"); // RULE_10 RULE_16
	property p_int_mask;
		ctrl_ff[`TEMU_C_IMASK] |=> !HOST_INT;
	endproperty
	a_int_mask: assert property (p_int_mask) else $error("masked interrupt"); // RULE_11
	property p_int_raise;
		halt_evt ##1 !ctrl_ff[`TEMU_C_IMASK] |=> HOST_INT;
	endproperty
	a_int_raise: assert property (p_int_raise) else $error("no interrupt"); // RULE_15
	property p_trace_dec;
		trace_wr && !tc_load |=> tcnt_ff == $past(tcnt_ff) - 16'h0001;
	endproperty
	a_trace_dec: assert property (p_trace_dec) else $error("counter stuck"); // RULE_17
	property p_full;
		full_evt |=> buf_full_ff && (tcnt_ff == 16'h0000);
	endproperty
	a_full: assert property (p_full) else $error("full missed"); // RULE_18
endmodule : temu_ctrl
`default_nettype wire

// ### tb/temu_tgt_model.sv
// Far-side model: target processor hold handshake and target memory.
// Assumes the emulator clock and the registered target memory port.
`timescale 1ns/1ns
`default_nettype none
module temu_tgt_model (
	// Clock and answer speed
	input  wire logic        clk,
	input  wire logic        slow,
	// Hold handshake
	input  wire logic        hold_req,
	output logic             hold_ack,
	// Target memory port
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wdata,
	output logic             ack,
	output logic [15:0]      rdata
);
	logic [1:0]  hs_ff;
	logic [2:0]  cnt_ff;
	logic [15:0] mem [0:255];
	// Known start values
	initial begin
		hs_ff = 2'h3;
		cnt_ff = 3'h0;
		hold_ack = 1'b1;
		ack = 1'b0;
		rdata = 16'h0;
	end
	// Hold acknowledge follows the hold request, both ways, three clocks later
	always @(posedge clk) begin
		hs_ff <= {hs_ff[0], hold_req};
		hold_ack <= hs_ff[1];
	end
	// Memory answers after one or four cycles; read data toggles when not valid
	always @(posedge clk) begin
		ack <= 1'b0;
		rdata <= ~rdata;
		if (req && !ack) begin
			if (cnt_ff == (slow ? 3'h3 : 3'h0)) begin
				ack <= 1'b1;
				cnt_ff <= 3'h0;
				if (we) mem[addr[8:1]] <= wdata;
				else rdata <= mem[addr[8:1]];
			end else cnt_ff <= cnt_ff + 3'h1;
		end
	end
endmodule : temu_tgt_model
`default_nettype wire

// ### tb/temu_ctrl_tb.sv
// Self-checking bench of the emulator control block over the host bit bus.
// Assumes the target model file is compiled before this one.
`timescale 1ns/1ns
`default_nettype none
module temu_ctrl_tb;
	// ==========================================================
	// Signals
	logic        clk = 1'b0, rst = 1'b1, bw = 1'b0, bd = 1'b0, cen = 1'b0, cwe = 1'b0;
	logic        ciaq = 1'b0, cend = 1'b0, tmh = 1'b0, slow = 1'b0, rq = 1'b0, rq_d = 1'b0;
	logic [4:0]  ba = 5'h0;
	logic [15:0] cadr = 16'h0, rv = 16'h0046, cv = 16'h0, tvec, taddr, twd, trd, eo, crd;
	logic        rd, hint, hreq, hack, treq, twe, tack, tl, tr, esel;
	logic        exq [$];
	int          failures = 0, compares = 0;
	// ==========================================================
	// Design and target model
	temu_ctrl uut (.CORE_CLK(clk), .RST(rst), .BIT_ADDR(ba), .BIT_WR(bw), .BIT_WR_DATA(bd),
		.BIT_RD_DATA(rd), .HOST_INT(hint), .HOLD_REQ(hreq), .HOLD_ACK(hack), .TGT_IDLE(1'b0),
		.TGT_WIDE_CPU(1'b1), .CLK_ERROR(1'b0), .TRAP_LOAD(tl), .TRAP_RESET(tr), .TRAP_VEC(tvec),
		.CPU_MEM_EN(cen), .CPU_WE(cwe), .CPU_IAQ(ciaq), .CPU_CYCLE_END(cend), .CPU_ADDR(cadr),
		.CPU_WDATA(rv), .EMU_SEL(esel), .CPU_RDATA(crd), .TRACE_CLK_EN(1'b0), .EXT_BREAK(1'b0),
		.TRACE_MOD_HALT(tmh), .EDGE_OUT(eo), .TGT_REQ(treq), .TGT_WE(twe), .TGT_ADDR(taddr),
		.TGT_WDATA(twd), .TGT_ACK(tack), .TGT_RDATA(trd));
	temu_tgt_model tgt (.clk(clk), .slow(slow), .hold_req(hreq), .hold_ack(hack), .req(treq),
		.we(twe), .addr(taddr), .wdata(twd), .ack(tack), .rdata(trd));
	// Clock
	always #50 clk = ~clk;
	// ==========================================================
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wbit(input logic [4:0] a, input logic v);
		@(posedge clk);
		ba <= a;
		bw <= 1'b1;
		bd <= v;
		@(posedge clk);
		bw <= 1'b0;
	endtask : wbit
	task automatic wword(input logic [4:0] b, input logic [15:0] w);
		for (int i = 0; i < 16; i++) wbit(b + 5'(i), w[i]);
	endtask : wword
	task automatic rbit(input logic [4:0] a, input logic e);
		@(posedge clk);
		ba <= a;
		rq <= 1'b1;
		exq.push_back(e);
		@(posedge clk);
		rq <= 1'b0;
	endtask : rbit
	task automatic rword(input logic [4:0] b, input logic [15:0] w);
		for (int i = 0; i < 16; i++) rbit(b + 5'(i), w[i]);
	endtask : rword
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : settle
	task automatic wint;
		for (int i = 0; i < 20 && hint !== 1'b1; i++) @(posedge clk);
		@(negedge clk);
	endtask : wint
	// Poll the pending status until the command is over
	task automatic done;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			ba <= 5'h12;
			settle(1);
			if (rd === 1'b0) break;
		end
	endtask : done
	// Address load and read, then write with read-back if w; v is expected, and written if w
	task automatic macc(input logic [15:0] a, input logic w, input logic [15:0] v);
		wword(5'h0, a);
		wbit(5'h12, 1'b1);
		done();
		if (w) begin
			wword(5'h0, v);
			wbit(5'h12, 1'b0);
			done();
		end
		rword(5'h0, v);
	endtask : macc
	task automatic cyc(input logic [15:0] a);
		rv = lfsr(rv);
		@(posedge clk);
		cadr <= a;
		cen <= 1'b1;
		cend <= 1'b1;
		cwe <= rv[0];
		ciaq <= rv[1];
		@(posedge clk);
		cend <= 1'b0;
		cen <= 1'b0;
	endtask : cyc
	task automatic end_of_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	// ==========================================================
	// Read monitor: oldest expected bit against the registered answer
	always @(posedge clk) rq_d <= rq;
	always @(negedge clk) if (rq_d) chk("status bit", {15'h0, rd}, {15'h0, exq.pop_front()});
	// Watchdog
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		end_of_test();
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		settle(4);
		chk("hold request", {15'h0, hreq}, 16'h1);
		rbit(5'h11, 1'b0);
		wbit(5'h10, 1'b1);
		settle(2);
		chk("hold request", {15'h0, hreq}, 16'h0);
		settle(4);
		rbit(5'h11, 1'b1);
		wbit(5'h10, 1'b0);
		settle(6);
		rbit(5'h11, 1'b0);
		wbit(5'h11, 1'b0);
		@(negedge clk);
		chk("load trap", {15'h0, tl}, 16'h1);
		settle(1);
		chk("trap vector", tvec, 16'hfffc);
		wbit(5'h11, 1'b1);
		@(negedge clk);
		chk("reset trap", {15'h0, tr}, 16'h1);
		settle(1);
		chk("trap vector", tvec, 16'h0000);
		$display("hold and trap test done");
		rv = lfsr(rv);
		slow <= 1'b1;
		macc(16'h4020, 1'b1, rv);
		slow <= 1'b0;
		macc(16'h4020, 1'b0, rv);
		wbit(5'h16, 1'b1);
		macc(16'h0020, 1'b1, ~rv);
		wbit(5'h16, 1'b0);
		macc(16'h0020, 1'b0, rv);
		wbit(5'h15, 1'b1);
		macc(16'hfe20, 1'b1, rv ^ 16'h00ff);
		wbit(5'h15, 1'b0);
		macc(16'hfe20, 1'b0, rv);
		$display("memory test done");
		wword(5'h0, rv);
		wbit(5'h14, 1'b0);
		wword(5'h0, 16'h0);
		wbit(5'h14, 1'b1);
		rword(5'h0, rv);
		wword(5'h0, 16'h0002);
		wbit(5'h13, 1'b0);
		wword(5'h0, 16'h0);
		wbit(5'h13, 1'b1);
		rword(5'h0, 16'h0002);
		$display("transfer test done");
		cv = rv;
		wbit(5'h1f, 1'b1);
		wbit(5'h18, 1'b0);
		wbit(5'h17, 1'b1);
		wbit(5'h10, 1'b1);
		settle(6);
		cyc(cv ^ 16'h0004);
		settle(4);
		chk("interrupt", {15'h0, hint}, 16'h0);
		chk("edge connector", eo, rv);
		cyc(cv);
		wint();
		chk("interrupt", {15'h0, hint}, 16'h1);
		settle(2);
		chk("hold request", {15'h0, hreq}, 16'h1);
		wbit(5'h18, 1'b1);
		settle(2);
		chk("interrupt", {15'h0, hint}, 16'h0);
		wbit(5'h17, 1'b0);
		wbit(5'h10, 1'b1);
		settle(6);
		cyc(cv);
		settle(4);
		chk("hold request", {15'h0, hreq}, 16'h0);
		rbit(5'h18, 1'b1);
		wbit(5'h1f, 1'b0);
		$display("breakpoint test done");
		wbit(5'h18, 1'b0);
		wbit(5'h1b, 1'b1);
		cyc(16'h0abc);
		wbit(5'h19, 1'b1);
		wbit(5'h1c, 1'b1);
		cyc(16'h1234);
		settle(3);
		chk("interrupt", {15'h0, hint}, 16'h0);
		chk("edge connector", eo, 16'h1234);
		cyc(16'h2346);
		wint();
		chk("interrupt", {15'h0, hint}, 16'h1);
		rbit(5'h1c, 1'b1);
		wbit(5'h10, 1'b0);
		settle(6);
		rbit(5'h11, 1'b0);
		wbit(5'h15, 1'b1);
		macc(16'hfe04, 1'b0, 16'h1234);
		macc(16'hfe02, 1'b0, 16'h2346);
		cyc(16'hfe04);
		@(negedge clk);
		chk("emulator select", {15'h0, esel}, 16'h1);
		settle(1);
		chk("emulator read", crd, 16'h1234);
		$display("trace test done");
		wbit(5'h18, 1'b0);
		settle(2);
		@(posedge clk);
		tmh <= 1'b1;
		@(posedge clk);
		tmh <= 1'b0;
		wint();
		chk("interrupt", {15'h0, hint}, 16'h1);
		$display("trace module halt test done");
		settle(3);
		end_of_test();
	end
endmodule : temu_ctrl_tb
`default_nettype wire
